// file: bench/adc_ctrl_checker.sv
// assertion checker on the ports of the converter control block
`include "adc_ctrl_consts.svh"
`default_nettype none
module adc_ctrl_checker (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       conv_done,
   input wire logic       start_conv,
   input wire logic       flush_conv,
   input wire logic       ev_result_done_out,
   input wire logic       ev_window_match_out,
   input wire logic [4:0] pos_input,
   input wire logic       pos_input_reserved,
   input wire logic       sampling_time_needed,
   input wire logic [4:0] neg_input,
   input wire logic       neg_input_reserved,
   input wire logic [2:0] gain_shift,
   input wire logic       gain_half,
   input wire logic       gain_reserved
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_result_cause: assert property (ev_result_done_out |-> $past(conv_done))
      else $error("result event without a finished conversion");
   a_window_cause: assert property (ev_window_match_out |-> $past(conv_done, 2))
      else $error("window event not two cycles after a conversion");
   a_flush_start: assert property (flush_conv |=> start_conv)
      else $error("flush not followed by start");
   a_gain_excl: assert property ($onehot0({gain_half, gain_reserved, gain_shift != 3'h0}))
      else $error("gain decode outputs overlap");
   a_gain_max: assert property (gain_shift <= `GAIN_MAX_MULT)
      else $error("gain shift beyond sixteen times");
   a_pos_reserved: assert property (pos_input_reserved ==
      ((pos_input > `POS_PIN_MAX && pos_input < `POS_TEMP) || pos_input > `POS_DAC))
      else $error("positive reserved flag wrong");
   a_pos_sampling: assert property (sampling_time_needed ==
      (pos_input == `POS_TEMP || pos_input == `POS_BANDGAP))
      else $error("sampling hint wrong");
   a_neg_reserved: assert property (neg_input_reserved ==
      !(neg_input <= `NEG_PIN_MAX || neg_input == `NEG_INT_GND || neg_input == `NEG_IO_GND))
      else $error("negative reserved flag wrong");
   a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("ready outside first access cycle");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking testbench of the converter control block
`include "adc_ctrl_consts.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_ctrl_pkg::*;
   localparam logic [7:0] A_CTL = 8'(`IDX_CONTROL * 4);
   localparam logic [7:0] A_WIN = 8'(`IDX_WINDOW_CTRL * 4);
   localparam logic [7:0] A_INS = 8'(`IDX_INPUT_SEL * 4);
   localparam logic [7:0] A_EVT = 8'(`IDX_EVENT_ROUTING * 4);
   localparam logic [7:0] A_CLR = 8'(`IDX_IRQ_EN_CLR * 4);
   localparam logic [7:0] A_SET = 8'(`IDX_IRQ_EN_SET * 4);
   localparam logic [7:0] A_FLG = 8'(`IDX_IRQ_FLAG * 4);
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        ev_convert_in = 1'b0, ev_flush_in = 1'b0, conv_done = 1'b0, overrun_in = 1'b0;
   apb_addr_t   paddr = 8'h00;
   apb_data_t   pwdata = 32'h0, prdata, rdata;
   logic [15:0] result_data = 16'h0200, win_lower = 16'h0100, win_upper = 16'hF000;
   logic        pready, pslverr, err, start_conv, flush_conv, ev_result_done_out, ev_window_match_out, irq;
   logic        pos_input_reserved, sampling_time_needed, neg_input_reserved, gain_half, gain_reserved;
   logic        converter_enable;
   logic [4:0]  pos_input, neg_input;
   logic [2:0]  gain_shift;
   int          fail_count = 0, checks_done = 0, cycles = 0;
   always #12.5 clk = ~clk;
   adc_input_scan_event_ctrl dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ev_convert_in, .ev_flush_in, .conv_done, .overrun_in, .result_data, .win_lower, .win_upper,
      .start_conv, .flush_conv, .ev_result_done_out, .ev_window_match_out, .irq, .pos_input, .pos_input_reserved,
      .sampling_time_needed, .neg_input, .neg_input_reserved, .gain_shift, .gain_half, .gain_reserved,
      .converter_enable);
   // ----------------------------------------
   // bus cycles and comparison
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, rdata, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic cv, input logic fl, input logic cd);
      @(posedge clk);
      ev_convert_in <= cv;
      ev_flush_in <= fl;
      conv_done <= cd;
      @(posedge clk);
      ev_convert_in <= 1'b0;
      ev_flush_in <= 1'b0;
      conv_done <= 1'b0;
      #1;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out;
      end
   end
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(A_EVT, 32'h0, "routing reset");
      rd(A_CLR, 32'h0, "irq enable reset");
      rd(A_INS, 32'h0, "input sel reset");
      rd(8'h04, 32'h0, "unmapped read");
      chk("unmapped error", err, 1);
      wr(A_EVT, 32'hFF);
      rd(A_EVT, 32'h33, "routing bits");
      wr(A_CTL, 32'h2);
      wr(A_WIN, 32'h1);
      idle(6);
      chk("enable", converter_enable, 1);
      for (int g = 0; g < 16; g++) begin
         wr(A_INS, 32'(g) << 24);
         idle(6);
         chk("gain shift", gain_shift, (g <= 4) ? g : 0);
         chk("gain half", gain_half, g == 15);
         chk("gain reserved", gain_reserved, g > 4 && g < 15);
      end
      for (int i = 0; i < 32; i++) begin
         wr(A_INS, (32'(i) << 8) | 32'(i));
         idle(6);
         chk("pos input", pos_input, i);
         chk("pos reserved", pos_input_reserved, (i > `POS_PIN_MAX && i < `POS_TEMP) || i > `POS_DAC);
         chk("sampling", sampling_time_needed, i == `POS_TEMP || i == `POS_BANDGAP);
         chk("neg input", neg_input, i);
         chk("neg reserved", neg_input_reserved, !(i <= `NEG_PIN_MAX || i == `NEG_INT_GND || i == `NEG_IO_GND));
      end
      pulse(1'b1, 1'b0, 1'b0);
      chk("start", {start_conv, flush_conv}, 2);
      pulse(1'b0, 1'b1, 1'b0);
      chk("flush", flush_conv, 1);
      idle(1);
      chk("start after flush", start_conv, 1);
      pulse(1'b0, 1'b0, 1'b1);
      chk("result event", ev_result_done_out, 1);
      idle(1);
      chk("window event", ev_window_match_out, 1);
      for (int m = 5; m > 0; m--) begin
         wr(A_WIN, m % 5);
         pulse(1'b0, 1'b0, 1'b1);
         idle(1);
         chk("window mode", ev_window_match_out, m < 4);
      end
      wr(A_EVT, 32'h0);
      pulse(1'b1, 1'b1, 1'b1);
      chk("events off", {start_conv, flush_conv, ev_result_done_out}, 0);
      idle(1);
      chk("events quiet", {start_conv, ev_window_match_out}, 0);
      wr(A_INS, 32'h0010_0002);
      idle(6);
      chk("offset start", pos_input, 3);
      pulse(1'b0, 1'b0, 1'b1);
      idle(4);
      chk("no scan", pos_input, 3);
      wr(A_INS, 32'h0012_0002);
      idle(6);
      for (int k = 0; k < 3; k++) begin
         pulse(1'b0, 1'b0, 1'b1);
         idle(4);
         chk("scan step", pos_input, (k == 2) ? 3 : 4 + k);
      end
      wr(A_FLG, 32'hF);
      wr(A_SET, 32'h1);
      rd(A_CLR, 32'h1, "enable set");
      pulse(1'b0, 1'b0, 1'b1);
      idle(2);
      chk("irq on", irq, 1);
      wr(A_CLR, 32'h1);
      idle(2);
      chk("irq off", irq, 0);
      rd(A_CLR, 32'h0, "enable cleared");
      wr(A_SET, 32'h1);
      idle(2);
      chk("pending dropped", irq, 0);
      wr(A_SET, 32'h8);
      wr(A_INS, 32'h0);
      idle(8);
      chk("sync done irq", irq, 1);
      close_out;
   end
endmodule
bind adc_input_scan_event_ctrl adc_ctrl_checker watch (.clk, .nrst, .psel, .penable, .pready, .pslverr,
   .conv_done, .start_conv, .flush_conv, .ev_result_done_out, .ev_window_match_out, .pos_input,
   .pos_input_reserved, .sampling_time_needed, .neg_input, .neg_input_reserved, .gain_shift, .gain_half,
   .gain_reserved);
`default_nettype wire

// file: logic/adc_input_scan_event_ctrl.sv
// converter input selection, pin scan, event routing and interrupt enable control with APB slave
//
// Summary of operation
// - gain code 0..4 gives 1x to 16x, 0xF half, 5..E reserved.
// - first conversion uses positive select plus start offset, or select alone if zero.
// - while scanning, each completed conversion bumps the scan offset by one, back to the start offset after the last.
// - scanning is on whenever the channel count field is nonzero.
// - a scan covers channel count plus one consecutive positive inputs.
// - negative codes 0..7 pins, 0x18 internal ground, 0x19 I/O ground.
// - positive codes 0x00..0x13 pins, 0x14..0x17 reserved.
// - positive codes 0x18..0x1C internal sources, 0x1D..0x1F reserved.
// - window match raises an output event while bit 5 is set.
// - result ready raises an output event while bit 4 is set.
// - with bit 1 set an incoming event flushes then starts a conversion.
// - with bit 0 set an incoming event starts a conversion.
// - ones written to the clear register drop enables and pending requests.
// - a set flag with its enable set raises the interrupt request.
// - ones written to the set register raise interrupt enables.
// - sync done sets when sync busy falls, unless caused by enable or reset.
// - window modes above, below, inside, outside, or off.
`include "adc_ctrl_consts.svh"
`default_nettype none
module adc_input_scan_event_ctrl (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire adc_ctrl_pkg::apb_addr_t  paddr,
   input  wire adc_ctrl_pkg::apb_data_t  pwdata,
   output adc_ctrl_pkg::apb_data_t       prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     ev_convert_in,
   input  wire logic                     ev_flush_in,
   input  wire logic                     conv_done,
   input  wire logic                     overrun_in,
   input  wire logic [15:0]              result_data,
   input  wire logic [15:0]              win_lower,
   input  wire logic [15:0]              win_upper,
   output logic                          start_conv,
   output logic                          flush_conv,
   output logic                          ev_result_done_out,
   output logic                          ev_window_match_out,
   output logic                          irq,
   output logic [4:0]                    pos_input,
   output logic                          pos_input_reserved,
   output logic                          sampling_time_needed,
   output logic [4:0]                    neg_input,
   output logic                          neg_input_reserved,
   output logic [2:0]                    gain_shift,
   output logic                          gain_half,
   output logic                          gain_reserved,
   output logic                          converter_enable
);
   import adc_ctrl_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [31:0]     input_selection_reg;
   logic [3:0]      scan_origin_reg;
   logic [3:0]      scan_step_reg;
   logic [7:0]      event_routing_reg;
   logic [3:0]      irq_enable_reg;
   logic [3:0]      irq_flag_reg;
   logic [2:0]      win_mode_reg;
   logic            enable_reg;
   logic [2:0]      sync_cnt_reg;
   logic            sync_by_reset_reg;
   logic            sync_busy_d_reg;
   trig_state_e     trig_state_reg;
   trig_state_e     trig_state_next;
   logic            win_match;
   logic [4:0]      neg_input_sel_reg;
   apb_data_t       prdata_reg;
   logic            pready_reg;
   logic            pslverr_reg;
   logic            start_reg;
   logic            flush_reg;
   logic            ev_res_reg;
   logic            ev_win_reg;
   logic            irq_reg;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   function automatic logic hit(input apb_addr_t addr, input logic [7:0] idx);
      hit = addr[7:2] == idx[5:0] && addr[1:0] == 2'b00;
   endfunction

   wire logic       acc          = psel && penable && pready_reg;
   wire logic       wr           = acc && pwrite;
   wire logic       hit_ctrl     = hit(paddr, `IDX_CONTROL);
   wire logic       hit_win      = hit(paddr, `IDX_WINDOW_CTRL);
   wire logic       hit_trig     = hit(paddr, `IDX_SW_TRIGGER);
   wire logic       hit_input    = hit(paddr, `IDX_INPUT_SEL);
   wire logic       hit_ev       = hit(paddr, `IDX_EVENT_ROUTING);
   wire logic       hit_clr      = hit(paddr, `IDX_IRQ_EN_CLR);
   wire logic       hit_set      = hit(paddr, `IDX_IRQ_EN_SET);
   wire logic       hit_flag     = hit(paddr, `IDX_IRQ_FLAG);
   wire logic       hit_status   = hit(paddr, `IDX_STATUS);
   wire logic       mapped       = hit_ctrl || hit_win || hit_trig || hit_input || hit_ev ||
                                   hit_clr || hit_set || hit_flag || hit_status;
   wire logic       wr_ctrl      = wr && hit_ctrl;
   wire logic       wr_input     = wr && hit_input;
   wire logic       wr_win       = wr && hit_win;
   wire logic       wr_trig      = wr && hit_trig;
   wire logic       swrst        = wr_ctrl && pwdata[`CTRL_SWRST_BIT];
   wire logic       enable_edge  = wr_ctrl && pwdata[`CTRL_ENABLE_BIT] != enable_reg;
   wire logic       sync_start   = wr_ctrl || wr_input || wr_win || wr_trig;

   // ----------------------------------------
   // scan control
   // ----------------------------------------
   wire logic [3:0] pos_offset   = input_selection_reg[`OFFSET_MSB:`OFFSET_LSB];
   wire logic [3:0] scan_count   = input_selection_reg[`SCAN_MSB:`SCAN_LSB];
   wire logic       scan_active  = scan_count != 4'h0;
   wire logic       scan_last    = scan_step_reg == scan_count;
   wire logic [3:0] offset_next  = scan_last ? scan_origin_reg : pos_offset + 4'h1;
   wire logic [3:0] step_next    = scan_last ? 4'h0 : scan_step_reg + 4'h1;

   // ----------------------------------------
   // triggers and events
   // ----------------------------------------
   wire logic       ev_start_ok  = enable_reg && ev_convert_in && event_routing_reg[`EV_CONV_IN_BIT];
   wire logic       ev_flush_ok  = enable_reg && ev_flush_in && event_routing_reg[`EV_FLUSH_IN_BIT];
   wire logic       sw_start     = enable_reg && wr_trig && pwdata[`TRIG_START_BIT];
   wire logic       sw_flush     = enable_reg && wr_trig && pwdata[`TRIG_FLUSH_BIT];
   wire logic       sync_busy    = sync_cnt_reg != 3'h0;
   wire logic       sync_fall    = sync_busy_d_reg && !sync_busy;

   always_comb begin
      case (trig_state_reg)
         TRIG_FLUSH: trig_state_next = TRIG_START;
         TRIG_IDLE,
         TRIG_START: trig_state_next = (ev_flush_ok || sw_flush) ? TRIG_FLUSH :
                                       (ev_start_ok || sw_start) ? TRIG_START : TRIG_IDLE;
         default:    trig_state_next = TRIG_IDLE;
      endcase
   end

   // ----------------------------------------
   // interrupt flags: set wins over clear
   // ----------------------------------------
   wire logic [3:0] flag_set     = {sync_fall && !sync_by_reset_reg, win_match, overrun_in, conv_done};
   wire logic [3:0] flag_clr     = (wr && hit_flag) ? pwdata[3:0] : 4'h0;
   wire logic [3:0] en_clr       = (wr && hit_clr) ? pwdata[3:0] : 4'h0;
   wire logic [3:0] en_set       = (wr && hit_set) ? pwdata[3:0] : 4'h0;
   wire logic [3:0] flag_next    = (irq_flag_reg & ~flag_clr & ~en_clr) | flag_set;
   wire logic [3:0] enable_next  = (irq_enable_reg & ~en_clr) | en_set;

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire apb_data_t  rd_data      =
      hit_ctrl   ? {30'h0, enable_reg, 1'b0} :
      hit_win    ? {29'h0, win_mode_reg} :
      hit_input  ? input_selection_reg :
      hit_ev     ? {24'h0, event_routing_reg} :
      (hit_clr || hit_set) ? {28'h0, irq_enable_reg} :
      hit_flag   ? {28'h0, irq_flag_reg} :
      hit_status ? {24'h0, sync_busy, 7'h00} : 32'h0000_0000;

   // ----------------------------------------
   // apb slave, one wait-free access phase
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= psel && !penable;
         pslverr_reg <= psel && !penable && !mapped;
         prdata_reg  <= (psel && !penable && !pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         input_selection_reg <= `INPUT_SEL_RESET;
         scan_origin_reg     <= 4'h0;
         scan_step_reg       <= 4'h0;
         event_routing_reg   <= `EVENT_ROUTING_RST;
         win_mode_reg        <= `WIN_OFF;
         enable_reg          <= 1'b0;
      end else if (swrst) begin
         input_selection_reg <= `INPUT_SEL_RESET;
         scan_origin_reg     <= 4'h0;
         scan_step_reg       <= 4'h0;
         event_routing_reg   <= `EVENT_ROUTING_RST;
         win_mode_reg        <= `WIN_OFF;
         enable_reg          <= 1'b0;
      end else begin
         if (wr_input) begin
            input_selection_reg <= pwdata & `INPUT_SEL_MASK;
            scan_origin_reg     <= pwdata[`OFFSET_MSB:`OFFSET_LSB];
            scan_step_reg       <= 4'h0;
         end else if (conv_done && scan_active) begin
            input_selection_reg[`OFFSET_MSB:`OFFSET_LSB] <= offset_next;
            scan_step_reg       <= step_next;
         end
         if (wr && hit_ev) begin
            event_routing_reg <= pwdata[7:0] & `EVENT_ROUTING_MASK;
         end
         if (wr_win) begin
            win_mode_reg <= pwdata[2:0];
         end
         if (wr_ctrl) begin
            enable_reg <= pwdata[`CTRL_ENABLE_BIT];
         end
      end
   end

   // ----------------------------------------
   // synchronization busy and interrupts
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_cnt_reg      <= 3'h0;
         sync_by_reset_reg <= 1'b0;
         sync_busy_d_reg   <= 1'b0;
         irq_enable_reg    <= `IRQ_EN_RESET;
         irq_flag_reg      <= 4'h0;
         irq_reg           <= 1'b0;
      end else begin
         if (sync_start) begin
            sync_cnt_reg      <= 3'(`SYNC_CYCLES);
            sync_by_reset_reg <= swrst || enable_edge;
         end else if (sync_busy) begin
            sync_cnt_reg <= sync_cnt_reg - 3'h1;
         end
         sync_busy_d_reg <= sync_busy;
         irq_enable_reg  <= swrst ? `IRQ_EN_RESET : enable_next;
         irq_flag_reg    <= flag_next;
         irq_reg         <= |(flag_next & enable_next);
      end
   end

   // ----------------------------------------
   // trigger sequencer and output events
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trig_state_reg    <= TRIG_IDLE;
         start_reg         <= 1'b0;
         flush_reg         <= 1'b0;
         ev_res_reg        <= 1'b0;
         ev_win_reg        <= 1'b0;
         neg_input_sel_reg <= 5'h00;
      end else begin
         trig_state_reg    <= trig_state_next;
         start_reg         <= trig_state_next == TRIG_START;
         flush_reg         <= trig_state_next == TRIG_FLUSH;
         ev_res_reg        <= conv_done && event_routing_reg[`EV_RES_OUT_BIT];
         ev_win_reg        <= win_match && event_routing_reg[`EV_WIN_OUT_BIT];
         neg_input_sel_reg <= input_selection_reg[`NEG_MSB:`NEG_LSB];
      end
   end

   // ----------------------------------------
   // input and gain decode
   // ----------------------------------------
   input_route_decode u_decode (
      .clk                   (clk),
      .nrst                  (nrst),
      .pos_sel               (input_selection_reg[`POS_MSB:`POS_LSB]),
      .neg_sel               (input_selection_reg[`NEG_MSB:`NEG_LSB]),
      .offset                (pos_offset),
      .gain                  (input_selection_reg[`GAIN_MSB:`GAIN_LSB]),
      .win_mode              (win_mode_reg),
      .result_valid          (conv_done),
      .result_data           (result_data),
      .win_lower             (win_lower),
      .win_upper             (win_upper),
      .eff_pos_reg           (pos_input),
      .pos_reserved_reg      (pos_input_reserved),
      .pos_sampling_hint_reg (sampling_time_needed),
      .neg_reserved_reg      (neg_input_reserved),
      .gain_shift_reg        (gain_shift),
      .gain_half_reg         (gain_half),
      .gain_reserved_reg     (gain_reserved),
      .win_match_reg         (win_match)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata              = prdata_reg;
   assign pready              = pready_reg;
   assign pslverr             = pslverr_reg;
   assign start_conv          = start_reg;
   assign flush_conv          = flush_reg;
   assign ev_result_done_out  = ev_res_reg;
   assign ev_window_match_out = ev_win_reg;
   assign irq                 = irq_reg;
   assign neg_input           = neg_input_sel_reg;
   assign converter_enable    = enable_reg;
endmodule
`default_nettype wire

// file: logic/input_route_decode.sv
// decodes input selection, gain and window compare into registered converter controls
`include "adc_ctrl_consts.svh"
`default_nettype none
module input_route_decode (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [4:0]  pos_sel,
   input  wire logic [4:0]  neg_sel,
   input  wire logic [3:0]  offset,
   input  wire logic [3:0]  gain,
   input  wire logic [2:0]  win_mode,
   input  wire logic        result_valid,
   input  wire logic [15:0] result_data,
   input  wire logic [15:0] win_lower,
   input  wire logic [15:0] win_upper,
   output logic      [4:0]  eff_pos_reg,
   output logic             pos_reserved_reg,
   output logic             pos_sampling_hint_reg,
   output logic             neg_reserved_reg,
   output logic      [2:0]  gain_shift_reg,
   output logic             gain_half_reg,
   output logic             gain_reserved_reg,
   output logic             win_match_reg
);
   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   function automatic logic pos_is_reserved(input logic [4:0] code);
      pos_is_reserved = (code > `POS_PIN_MAX && code < `POS_TEMP) || code > `POS_DAC;
   endfunction

   function automatic logic neg_is_reserved(input logic [4:0] code);
      neg_is_reserved = code > `NEG_PIN_MAX && code != `NEG_INT_GND && code != `NEG_IO_GND;
   endfunction

   // ----------------------------------------
   // combinational selection
   // ----------------------------------------
   wire logic [4:0] eff_pos  = pos_sel + {1'b0, offset};
   wire logic       g_half   = gain == `GAIN_HALF;
   wire logic       g_mult   = gain <= `GAIN_MAX_MULT;
   wire logic       above    = result_data > win_lower;
   wire logic       below    = result_data < win_upper;
   wire logic       in_match = (win_mode == `WIN_ABOVE   && above) ||
                               (win_mode == `WIN_BELOW   && below) ||
                               (win_mode == `WIN_INSIDE  && above && below) ||
                               (win_mode == `WIN_OUTSIDE && !(above && below));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eff_pos_reg           <= 5'h00;
         pos_reserved_reg      <= 1'b0;
         pos_sampling_hint_reg <= 1'b0;
         neg_reserved_reg      <= 1'b0;
         gain_shift_reg        <= 3'h0;
         gain_half_reg         <= 1'b0;
         gain_reserved_reg     <= 1'b0;
         win_match_reg         <= 1'b0;
      end else begin
         eff_pos_reg           <= eff_pos;
         pos_reserved_reg      <= pos_is_reserved(eff_pos);
         pos_sampling_hint_reg <= eff_pos == `POS_TEMP || eff_pos == `POS_BANDGAP;
         neg_reserved_reg      <= neg_is_reserved(neg_sel);
         gain_shift_reg        <= g_mult ? gain[2:0] : 3'h0;
         gain_half_reg         <= g_half;
         gain_reserved_reg     <= !g_mult && !g_half;
         win_match_reg         <= result_valid && in_match;
      end
   end
endmodule
`default_nettype wire

// file: pkg/adc_ctrl_consts.svh
// register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_CONTROL        8'h00
`define IDX_WINDOW_CTRL    8'h08
`define IDX_SW_TRIGGER     8'h0C
`define IDX_INPUT_SEL      8'h10
`define IDX_EVENT_ROUTING  8'h14
`define IDX_IRQ_EN_CLR     8'h16
`define IDX_IRQ_EN_SET     8'h17
`define IDX_IRQ_FLAG       8'h18
`define IDX_STATUS         8'h19

// input selection fields
`define GAIN_MSB           27
`define GAIN_LSB           24
`define OFFSET_MSB         23
`define OFFSET_LSB         20
`define SCAN_MSB           19
`define SCAN_LSB           16
`define NEG_MSB            12
`define NEG_LSB            8
`define POS_MSB            4
`define POS_LSB            0
`define INPUT_SEL_RESET    32'h0000_0000
`define INPUT_SEL_MASK     32'h0FFF_1F1F

// event routing bits
`define EV_WIN_OUT_BIT     5
`define EV_RES_OUT_BIT     4
`define EV_FLUSH_IN_BIT    1
`define EV_CONV_IN_BIT     0
`define EVENT_ROUTING_MASK 8'h33
`define EVENT_ROUTING_RST  8'h00

// interrupt bits
`define IRQ_RES_BIT        0
`define IRQ_OVR_BIT        1
`define IRQ_WIN_BIT        2
`define IRQ_SYNC_BIT       3
`define IRQ_EN_RESET       4'h0

// control and trigger bits
`define CTRL_SWRST_BIT     0
`define CTRL_ENABLE_BIT    1
`define TRIG_FLUSH_BIT     0
`define TRIG_START_BIT     1
`define STATUS_BUSY_BIT    7

// gain codes
`define GAIN_MAX_MULT      4'h4
`define GAIN_HALF          4'hF

// input selection codes
`define NEG_PIN_MAX        5'h07
`define NEG_INT_GND        5'h18
`define NEG_IO_GND         5'h19
`define POS_PIN_MAX        5'h13
`define POS_TEMP           5'h18
`define POS_BANDGAP        5'h19
`define POS_DAC            5'h1C

// window compare modes
`define WIN_OFF            3'h0
`define WIN_ABOVE          3'h1
`define WIN_BELOW          3'h2
`define WIN_INSIDE         3'h3
`define WIN_OUTSIDE        3'h4

// register synchronization time
`define SYNC_TIME_NS       75
`define CLK_PERIOD_NS      25
`define SYNC_CYCLES        ((`SYNC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: pkg/adc_ctrl_pkg.sv
// types shared by the converter control block
`default_nettype none
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      TRIG_IDLE  = 2'b00,
      TRIG_FLUSH = 2'b01,
      TRIG_START = 2'b10
   } trig_state_e;
   typedef logic [7:0]  apb_addr_t;
   typedef logic [31:0] apb_data_t;
endpackage
`default_nettype wire
